// ---- verilog/adcctl_host.sv ----
// host controller driving the half-flash converter through its bus pins
`timescale 1ns/100ps
`default_nettype none
// Operation
// - select low needed for any strobe
// - wait 900 ns after wake before converting
// - in sleep: mode low, others high
// - read mode: read strobe low starts conversion
// - hold read strobe low until data ready
// - write-read: track, convert on write fall
// - track interval from done before next write
// - internal delay: wait done, then read
// - early read finishes conversion at once
// - tied strobes: each write pulse converts
module adcctl_host #(
  parameter int unsigned FIFO_W = adcctl_pkg::DATA_W,
  parameter int unsigned FIFO_D = adcctl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user control
  input wire logic enable,
  input wire logic write_read_mode,
  input wire logic early_read,
  output logic busy,
  // result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [FIFO_W-1:0] res_data,
  // converter pins
  output logic sleep_n,
  output logic mode,
  output logic select_n,
  output logic read_strobe_n,
  output logic convert_strobe_n,
  output logic convert_strobe_oe_n,
  input wire logic ready_in,
  input wire logic conv_done_n,
  input wire logic [adcctl_pkg::DATA_W-1:0] result_bus
);
  import adcctl_pkg::*;

  typedef struct packed {
    adcctl_state_e state;
    logic [CNT_W-1:0] cnt;
    logic wr_mode;
    logic early;
    logic sleep_n;
    logic select_n;
    logic rd_n;
    logic wr_n;
    logic push;
    logic [DATA_W-1:0] data;
  } adcctl_host_s;

  adcctl_host_s st_q;
  adcctl_host_s st_d;
  logic fifo_ready;
  logic cnt_zero;
  logic gap_over;

  assign cnt_zero = (st_q.cnt == '0);
  // early read ends the gap on the count, otherwise the done flag ends it
  assign gap_over = st_q.early ? cnt_zero : !conv_done_n;

  adcctl_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(st_q.push),
    .in_ready(fifo_ready),
    .in_data(FIFO_W'(st_q.data)),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  assign sleep_n = st_q.sleep_n;
  assign mode = st_q.wr_mode;
  assign select_n = st_q.select_n;
  assign read_strobe_n = st_q.rd_n;
  assign convert_strobe_n = st_q.wr_n;
  // shared pin is driven by us only in write-read mode
  assign convert_strobe_oe_n = !st_q.wr_mode;
  assign busy = (st_q.state != ST_SLEEP);

  always_comb begin
    st_d = st_q;
    st_d.push = 1'b0;
    if (!cnt_zero) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
    case (st_q.state)
      ST_SLEEP: begin
        // idle inputs high, mode low in shutdown
        st_d.wr_mode = MODE_READ;
        st_d.select_n = 1'b1;
        st_d.rd_n = 1'b1;
        st_d.wr_n = 1'b1;
        st_d.sleep_n = 1'b0;
        if (enable) begin
          st_d.sleep_n = 1'b1;
          if (write_read_mode) begin
            st_d.wr_mode = MODE_WRITE_READ;
          end else begin
            st_d.wr_mode = MODE_READ;
          end
          st_d.early = early_read;
          st_d.cnt = CNT_W'(WAKE_CYC);
          st_d.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (cnt_zero) begin
          st_d.cnt = CNT_W'(TRACK_CYC);
          st_d.state = ST_TRACK;
        end
      end
      ST_TRACK: begin
        // track interval before each start
        // a full fifo holds us here, so no result is ever dropped
        if (!enable) begin
          st_d.state = ST_SLEEP;
        end else if (cnt_zero && fifo_ready) begin
          st_d.select_n = 1'b0;
          st_d.cnt = CNT_W'(CS_RDY_CYC);
          st_d.state = ST_SEL;
        end
      end
      ST_SEL: begin
        if (cnt_zero) begin
          if (st_q.wr_mode) begin
            st_d.wr_n = 1'b0;
            st_d.cnt = CNT_W'(WR_PULSE_CYC);
            st_d.state = ST_WR_LOW;
          end else begin
            st_d.rd_n = 1'b0;
            st_d.cnt = CNT_W'(CONV_RD_CYC);
            st_d.state = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        // read held low until ready goes high
        if (cnt_zero && ready_in) begin
          // data trails ready, so the read stays low one more access time
          st_d.cnt = CNT_W'(READ2_CYC);
          st_d.state = ST_RD_LOW;
        end
      end
      ST_WR_LOW: begin
        if (cnt_zero) begin
          st_d.wr_n = 1'b1;
          if (st_q.early) begin
            st_d.cnt = CNT_W'(WR_TO_RD_CYC);
          end else begin
            st_d.cnt = '0;
          end
          st_d.state = ST_WR_GAP;
        end
      end
      ST_WR_GAP: begin
        if (gap_over) begin
          st_d.rd_n = 1'b0;
          if (st_q.early) begin
            st_d.cnt = CNT_W'(READ_CYC);
          end else begin
            st_d.cnt = CNT_W'(READ2_CYC);
          end
          st_d.state = ST_RD_LOW;
        end
      end
      ST_RD_LOW: begin
        if (cnt_zero) begin
          st_d.state = ST_RD_HOLD;
        end
      end
      ST_RD_HOLD: begin
        // sample while device drives the bus
        st_d.data = result_bus;
        st_d.push = 1'b1;
        st_d.rd_n = 1'b1;
        st_d.select_n = 1'b1;
        st_d.state = ST_DONE;
      end
      ST_DONE: begin
        st_d.cnt = CNT_W'(TRACK_CYC);
        st_d.state = ST_TRACK;
      end
      default: begin
        st_d.state = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // converter starts shut down with every strobe idle high
      st_q <= '{
        state: ST_SLEEP,
        cnt: '0,
        wr_mode: 1'b0,
        early: 1'b0,
        sleep_n: 1'b0,
        select_n: 1'b1,
        rd_n: 1'b1,
        wr_n: 1'b1,
        push: 1'b0,
        data: '0
      };
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/adcctl_pkg.sv ----
// package of timing counts and enumerations for the converter bus controller
package adcctl_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // least times in ns as printed
  localparam int unsigned WAKE_NS = 900;
  localparam int unsigned TRACK_NS = 450;
  localparam int unsigned WR_PULSE_NS = 600;
  localparam int unsigned WR_TO_RD_NS = 800;
  localparam int unsigned READ_PULSE_NS = 400;
  localparam int unsigned READ2_PULSE_NS = 180;
  localparam int unsigned CS_RDY_NS = 100;
  localparam int unsigned CONV_RD_NS = 2000;
  // least times round up to whole cycles
  localparam int unsigned WAKE_CYC = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TRACK_CYC = (TRACK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_PULSE_CYC = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_TO_RD_CYC = (WR_TO_RD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned READ_CYC = (READ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned READ2_CYC = (READ2_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CS_RDY_CYC = (CS_RDY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_RD_CYC = (CONV_RD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  // mode pin values
  localparam logic MODE_READ = 1'b0;
  localparam logic MODE_WRITE_READ = 1'b1;

  typedef enum logic [9:0] {
    ST_SLEEP = 10'h001,
    ST_WAKE = 10'h002,
    ST_TRACK = 10'h004,
    ST_SEL = 10'h008,
    ST_RD_WAIT = 10'h010,
    ST_WR_LOW = 10'h020,
    ST_WR_GAP = 10'h040,
    ST_RD_LOW = 10'h080,
    ST_RD_HOLD = 10'h100,
    ST_DONE = 10'h200
  } adcctl_state_e;
endpackage

// ---- verilog/adcctl_fifo.sv ----
// small result fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module adcctl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] dout;
  } adcctl_fifo_s;

  adcctl_fifo_s st_q;
  adcctl_fifo_s st_d;
  logic push;
  logic pop;

  assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.dout;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // head word registered for the read port
    if (st_d.cnt == '0) begin
      st_d.dout = '0;
    end else if (st_q.cnt == '0 || (pop && st_q.cnt == (AW+1)'(1))) begin
      st_d.dout = in_data;
    end else begin
      st_d.dout = st_d.mem[st_d.rd];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// ---- test/adcctl_props.sv ----
// pin timing checks on the converter host controller
`timescale 1ns/100ps
`default_nettype none
module adcctl_props
  import adcctl_pkg::*;
(
  // clock, reset and user side
  input wire logic clk,
  input wire logic reset,
  input wire logic early_read,
  input wire logic res_valid,
  input wire logic res_ready,
  // converter pins
  input wire logic mode,
  input wire logic select_n,
  input wire logic read_strobe_n,
  input wire logic convert_strobe_n,
  input wire logic convert_strobe_oe_n,
  input wire logic ready_in,
  input wire logic conv_done_n,
  input wire logic sleep_n
);
  logic [8:0] wake_q, trk_q, wr_q;
  logic done_q;
  function automatic logic [8:0] sat(logic [8:0] x);
    return (&x) ? x : x + 9'h001;
  endfunction
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_q <= 9'h000;
      trk_q <= 9'h1FF;
      wr_q <= 9'h000;
      done_q <= 1'b1;
    end else begin
      done_q <= conv_done_n;
      wake_q <= sleep_n ? sat(wake_q) : 9'h000;
      trk_q <= (done_q && !conv_done_n) ? 9'h000 : sat(trk_q);
      wr_q <= convert_strobe_n ? 9'h000 : sat(wr_q);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wake_wait_a: assert property ($fell(select_n) |-> wake_q >= WAKE_CYC)
    else $error("select fell before wake time");
  strobe_sel_a: assert property (!(read_strobe_n && convert_strobe_n) |-> !select_n)
    else $error("strobe low without select");
  mode_hold_a: assert property (sleep_n && $past(sleep_n) |-> $stable(mode))
    else $error("mode moved while awake");
  pin_drive_a: assert property ((convert_strobe_oe_n != mode) && (!convert_strobe_oe_n || convert_strobe_n))
    else $error("shared pin driven in read mode");
  track_gap_a: assert property ($fell(convert_strobe_n) |-> trk_q >= TRACK_CYC)
    else $error("write too soon after done");
  wr_width_a: assert property ($rose(convert_strobe_n) |-> wr_q >= WR_PULSE_CYC)
    else $error("write pulse too short");
  ready_wait_a: assert property (!mode && !read_strobe_n && !ready_in |=> !read_strobe_n)
    else $error("read released before ready");
  done_read_a: assert property (mode && !early_read && $fell(read_strobe_n) |-> !conv_done_n)
    else $error("read before done flag");
  cover property ($fell(read_strobe_n) && early_read && mode);
  cover property ($rose(ready_in) && !mode);
  cover property (res_valid && !res_ready);
endmodule
`default_nettype wire

// ---- test/adcctl_dev_model.sv ----
// behavioural model of the converter on the far side of the pins
`timescale 1ns/100ps
`default_nettype none
module adcctl_dev_model (
  // clock and test control
  input wire logic clk,
  input wire logic [7:0] sample,
  input wire logic [8:0] done_cyc,
  output logic taken,
  // converter pins
  input wire logic sleep_n,
  input wire logic mode,
  input wire logic select_n,
  input wire logic read_strobe_n,
  input wire logic convert_strobe_n,
  input wire logic convert_strobe_oe_n,
  output logic ready_in,
  output logic conv_done_n,
  output logic [7:0] result_bus
);
  logic [7:0] hold_q = 8'h00, smp_q = 8'h00;
  logic [8:0] cnt_q = 9'h000;
  logic busy_q = 1'b0, rd_q = 1'b1, cs_q = 1'b1, wr_q = 1'b1;
  logic wr_pin;
  initial taken = 1'b0;
  initial conv_done_n = 1'b1;
  assign wr_pin = convert_strobe_oe_n | convert_strobe_n;
  // an undriven bus has no pull, so it shows the inverse of the last data
  assign result_bus = (!select_n && !read_strobe_n) ? hold_q : ~hold_q;
  assign ready_in = mode | !busy_q;
  always @(posedge clk) begin
    taken <= 1'b0;
    rd_q <= read_strobe_n;
    cs_q <= select_n;
    wr_q <= wr_pin;
    if (!sleep_n) begin
      busy_q <= 1'b0;
      conv_done_n <= 1'b1;
    end else begin
      if (read_strobe_n && !rd_q || select_n && !cs_q) conv_done_n <= 1'b1;
      if (!select_n && !busy_q && (mode ? !wr_pin && wr_q : !read_strobe_n && rd_q)) begin
        busy_q <= 1'b1;
        cnt_q <= 9'h000;
        smp_q <= sample;
        taken <= 1'b1;
      end
      if (busy_q && mode && wr_pin && !wr_q) hold_q[7:4] <= smp_q[7:4];
      if (busy_q && (!mode || wr_pin)) cnt_q <= cnt_q + 9'h001;
      if (busy_q && (cnt_q == done_cyc || mode && wr_pin && !read_strobe_n && rd_q)) begin
        busy_q <= 1'b0;
        hold_q <= smp_q;
        conv_done_n <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the converter host controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import adcctl_pkg::*;
  logic clk = 1'b0, reset = 1'b1, enable = 1'b0, write_read_mode = 1'b0, early_read = 1'b0;
  logic res_ready = 1'b0, stall = 1'b0, busy, res_valid, sleep_n, mode, select_n, taken;
  logic read_strobe_n, convert_strobe_n, convert_strobe_oe_n, ready_in, conv_done_n;
  logic [7:0] res_data, result_bus, sample = 8'h00;
  logic [8:0] done_cyc = 9'h03C;
  logic [7:0] exp_q[$];
  int num_errors = 0, comparisons = 0, got = 0, cyc = 0;
  adcctl_host u_adcctl_host (.clk(clk), .reset(reset), .enable(enable),
    .write_read_mode(write_read_mode), .early_read(early_read), .busy(busy),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data), .sleep_n(sleep_n),
    .mode(mode), .select_n(select_n), .read_strobe_n(read_strobe_n),
    .convert_strobe_n(convert_strobe_n), .convert_strobe_oe_n(convert_strobe_oe_n),
    .ready_in(ready_in), .conv_done_n(conv_done_n), .result_bus(result_bus));
  adcctl_dev_model u_adcctl_dev_model (.clk(clk), .sample(sample), .done_cyc(done_cyc),
    .taken(taken), .sleep_n(sleep_n), .mode(mode), .select_n(select_n),
    .read_strobe_n(read_strobe_n), .convert_strobe_n(convert_strobe_n),
    .convert_strobe_oe_n(convert_strobe_oe_n), .ready_in(ready_in),
    .conv_done_n(conv_done_n), .result_bus(result_bus));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
    comparisons++;
    if (exp !== seen) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic settle();
    for (int i = 0; i < 3000 && (busy !== 1'b0 || exp_q.size() > 0); i++) @(posedge clk);
  endtask
  // driver side: note each sampled value, pick the next, stall the drain at will
  always @(posedge clk) begin
    res_ready <= stall ? 1'b0 : 1'($urandom % 2);
    if (taken) begin
      exp_q.push_back(sample);
      sample <= 8'($urandom);
    end
  end
  // watcher side: each popped result against the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (res_valid === 1'b1 && res_ready) begin
      got <= got + 1;
      check("result", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, res_data);
    end
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'hC7D173A0));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // read mode, write-read with internal delay, then early read; prompt and slow device
    for (int k = 0; k < 6; k++) begin
      write_read_mode <= 1'(k > 1);
      early_read <= 1'(k > 3);
      done_cyc <= (k % 2) ? 9'h12C : 9'h03C;
      enable <= 1'b1;
      for (int i = 0; i < 9000 && got < 3 * (k + 1); i++) @(posedge clk);
      check("mode", 8'(write_read_mode), 8'(mode));
      enable <= 1'b0;
      settle();
      @(posedge clk);
      check("pending", 8'h00, 8'(exp_q.size()));
      check("converted", 8'h01, 8'(got >= 3 * (k + 1)));
      check("asleep", 8'h07, 8'({busy, sleep_n, mode, select_n, read_strobe_n, convert_strobe_n}));
      $display("test %0d mode %0d early %0d done", k, write_read_mode, early_read);
    end
    stall <= 1'b1;
    enable <= 1'b1;
    for (int i = 0; i < 9000 && exp_q.size() < FIFO_DEPTH; i++) @(posedge clk);
    repeat (1500) @(posedge clk);
    check("held", 8'(FIFO_DEPTH), 8'(exp_q.size()));
    enable <= 1'b0;
    stall <= 1'b0;
    settle();
    check("drained", 8'h00, 8'(exp_q.size()));
    $display("test fifo fill done");
    stop_test();
  end
endmodule
bind adcctl_host adcctl_props u_adcctl_props (.clk(clk), .reset(reset),
  .early_read(early_read), .res_valid(res_valid), .res_ready(res_ready), .mode(mode),
  .select_n(select_n), .read_strobe_n(read_strobe_n), .convert_strobe_n(convert_strobe_n),
  .convert_strobe_oe_n(convert_strobe_oe_n), .ready_in(ready_in),
  .conv_done_n(conv_done_n), .sleep_n(sleep_n));
`default_nettype wire
